// >>> rtl/epc_pkg.sv
// Package with register map, field positions and reset values for the EPROM program control
package epc_pkg;

	// ==================================================
	// Register offsets (byte addresses on the register port)
	localparam logic [3:0] EPC_OFF_CONTROL = 4'h0;  // eprom_program_control
	localparam logic [3:0] EPC_OFF_OPTION  = 4'h4;  // mask_option_byte image
	localparam logic [3:0] EPC_OFF_SECURE  = 4'h8;  // secure-state status

	// ==================================================
	// Field positions in eprom_program_control
	localparam int EPC_BIT_LATCH = 0;
	localparam int EPC_BIT_PROG  = 1;
	localparam int EPC_BIT_HVABS = 2;

	// Secure option bit in mask_option_byte
	localparam int EPC_BIT_SECURE_OPT = 3;

	// ==================================================
	// Reset values and constant read patterns
	localparam logic       EPC_LATCH_RST  = 1'b1;
	localparam logic       EPC_PROG_RST   = 1'b1;
	localparam logic [4:0] EPC_UNIMP_READ = 5'h1f;

	// ==================================================
	// Secure signature locations and contents
	localparam logic [10:0] EPC_SIG_ADDR_LO = 11'h782;
	localparam logic [10:0] EPC_SIG_ADDR_HI = 11'h783;
	localparam logic [7:0]  EPC_SIG_VAL_LO  = 8'h20;
	localparam logic [7:0]  EPC_SIG_VAL_HI  = 8'hfe;

	// Secure tracker states
	typedef enum logic [1:0] {
		EPC_SEC_OPEN,
		EPC_SEC_ARMED,
		EPC_SEC_LOCKED
	} epc_sec_e;

endpackage // epc_pkg

// >>> rtl/epc_secure.sv
// Secure-mode tracker: latches secure state from option bit and signature bytes
`timescale 1ns/1ps
module epc_secure
	import epc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_sync_b,
	input  wire logic        option_secure,
	input  wire logic [7:0]  sig_lo,
	input  wire logic [7:0]  sig_hi,
	input  wire logic        array_erased,
	output logic             secure_on
);

	epc_sec_e state_q;
	epc_sec_e state_d;
	logic     sig_ok;

	// ==================================================
	// Signature match on both bytes
	assign sig_ok = (sig_lo == EPC_SIG_VAL_LO) && (sig_hi == EPC_SIG_VAL_HI);

	// Next state: locked only with option bit and signature, left only by full erase
	always_comb begin
		state_d = state_q;
		case (state_q)
			EPC_SEC_OPEN: begin
				if (option_secure) begin
					state_d = EPC_SEC_ARMED;
				end
			end
			EPC_SEC_ARMED: begin
				if (option_secure && sig_ok) begin
					state_d = EPC_SEC_LOCKED;
				end else if (!option_secure) begin
					state_d = EPC_SEC_OPEN;
				end
			end
			EPC_SEC_LOCKED: begin
				if (array_erased) begin
					state_d = EPC_SEC_OPEN;
				end
			end
			default: state_d = EPC_SEC_OPEN;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_q <= EPC_SEC_OPEN;
		end else begin
			state_q <= state_d;
		end
	end

	assign secure_on = (state_q == EPC_SEC_LOCKED);

endmodule // epc_secure

// >>> rtl/epc_program_control.sv
// EPROM programming control register with high-voltage interlock and secure mode
// Notes on behaviour
// - The latch bit at 0 latches address and data into the array, at 1 the array reads; reset gives 1.
// - The program bit at 0 programs only while the latch bit is 0; at 1 it inhibits; reset gives 1.
// - The voltage-sense bit is read-only, 0 with high voltage present and 1 without.
// - While the voltage-sense bit is 1 both strobes are cut off from the array.
// - Sense, program and latch all 0 put the array in programming of the latched byte.
// - In secure mode the bootstrap programming routine is refused.
// - Secure mode needs option bit 3 set and bytes 20h and FEh at 782h and 783h.
// - Leaving secure mode takes a full erase of the array.
// - With the secure option bit set, external access to the array is blocked.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module epc_program_control
	import epc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Programming-voltage sense, high while voltage is absent
	input  wire logic        high_voltage_absent,
	// Option byte and signature bytes as read from the array
	input  wire logic [7:0]  mask_option_byte,
	input  wire logic [7:0]  sig_lo,
	input  wire logic [7:0]  sig_hi,
	input  wire logic        array_erased,
	// Bootstrap and external access requests
	input  wire logic        boot_prog_req,
	input  wire logic        ext_access_req,
	// Array strobes, active low, then status and access flags, active high
	output logic             latch_strobe_n,
	output logic             program_strobe_n,
	output logic             program_active,
	output logic             boot_prog_allow,
	output logic             ext_access_allow,
	output logic             secure_active
);

	// ==================================================
	// Decode helpers, all but sig_match used in more than one path

	// Register port address selects the control register
	function automatic logic hit_ctrl(input logic [3:0] addr);
		return (addr == EPC_OFF_CONTROL);
	endfunction

	// Secure option bit of the option byte
	function automatic logic opt_secure(input logic [7:0] opt);
		return opt[EPC_BIT_SECURE_OPT];
	endfunction

	// Both signature bytes hold the secure pattern
	function automatic logic sig_match(input logic [7:0] lo, input logic [7:0] hi);
		return (lo == EPC_SIG_VAL_LO) && (hi == EPC_SIG_VAL_HI);
	endfunction

	// ==================================================
	// Reset synchroniser
	logic rst_meta_q;
	logic rst_sync_b;

	// Two-stage release of the asynchronous reset
	// Only the second stage feeds the rest of the block
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_b <= rst_meta_q;
		end
	end

	// ==================================================
	// Control register
	logic latch_q;
	logic latch_d;
	logic prog_q;
	logic prog_d;
	logic wr_ctrl;

	// Write strobe aimed at the control register; other offsets are read-only
	assign wr_ctrl = reg_wr && hit_ctrl(reg_addr);

	// Next values of the writable bits; upper bits are not stored
	always_comb begin
		latch_d = latch_q;
		prog_d  = prog_q;
		if (wr_ctrl) begin
			latch_d = reg_wdata[EPC_BIT_LATCH];
			prog_d  = reg_wdata[EPC_BIT_PROG];
		end
	end

	// Register the control bits, both set by reset
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			latch_q <= EPC_LATCH_RST;
			prog_q  <= EPC_PROG_RST;
		end else begin
			latch_q <= latch_d;
			prog_q  <= prog_d;
		end
	end

	// ==================================================
	// Secure mode tracker
	logic secure_on;
	logic sec_live;

	// Secure condition straight from the array contents; it covers the cycles
	// after reset in which the tracker has not yet reached its locked state
	assign sec_live = opt_secure(mask_option_byte) && sig_match(sig_lo, sig_hi);

	epc_secure u_secure (
		.clk_sys       (clk_sys),
		.rst_sync_b    (rst_sync_b),
		.option_secure (opt_secure(mask_option_byte)),
		.sig_lo        (sig_lo),
		.sig_hi        (sig_hi),
		.array_erased  (array_erased),
		.secure_on     (secure_on)
	);

	// ==================================================
	// Strobe outputs with voltage interlock
	logic latch_n_d;
	logic prog_n_d;
	logic active_d;
	logic boot_d;
	logic ext_d;
	logic latch_n_q;
	logic prog_n_q;
	logic active_q;
	logic boot_q;
	logic ext_q;
	logic sec_q;

	// Interlock disconnects both strobes when voltage is absent
	// A program setting without the latch setting never reaches the array
	always_comb begin
		latch_n_d = 1'b1;
		prog_n_d  = 1'b1;
		if (!high_voltage_absent) begin
			latch_n_d = latch_q;
			prog_n_d  = prog_q | latch_q;
		end
		active_d = !high_voltage_absent && !prog_q && !latch_q;
		boot_d   = boot_prog_req && !secure_on && !sec_live;
		ext_d    = ext_access_req && !opt_secure(mask_option_byte);
	end

	// Output flip-flops, all idle under reset
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			latch_n_q <= 1'b1;
			prog_n_q  <= 1'b1;
			active_q  <= 1'b0;
			boot_q    <= 1'b0;
			ext_q     <= 1'b0;
			sec_q     <= 1'b0;
		end else begin
			latch_n_q <= latch_n_d;
			prog_n_q  <= prog_n_d;
			active_q  <= active_d;
			boot_q    <= boot_d;
			ext_q     <= ext_d;
			sec_q     <= secure_on;
		end
	end

	assign latch_strobe_n   = latch_n_q;
	assign program_strobe_n = prog_n_q;
	assign program_active   = active_q;
	assign boot_prog_allow  = boot_q;
	assign ext_access_allow = ext_q;
	assign secure_active    = sec_q;

	// ==================================================
	// Read path, data in the cycle after the read strobe
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;

	// Address decode of readable registers
	// Idle cycles and unmapped offsets read as zero
	always_comb begin
		rdata_d = 8'h00;
		if (reg_rd) begin
			if (hit_ctrl(reg_addr)) begin
				rdata_d = {EPC_UNIMP_READ, high_voltage_absent, prog_q, latch_q};
			end else if (reg_addr == EPC_OFF_OPTION) begin
				rdata_d = mask_option_byte;
			end else if (reg_addr == EPC_OFF_SECURE) begin
				rdata_d = {7'h00, secure_on};
			end else begin
				rdata_d = 8'h00;
			end
		end
	end

	// Read data register
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

endmodule // epc_program_control

// >>> sim/epc_assertions.sv
// Port assertions for the EPROM program control
`timescale 1ns/1ps
module epc_checker
	import epc_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       high_voltage_absent,
	input wire logic [7:0] mask_option_byte,
	input wire logic [7:0] sig_lo,
	input wire logic [7:0] sig_hi,
	input wire logic       array_erased,
	input wire logic       latch_strobe_n,
	input wire logic       program_strobe_n,
	input wire logic       program_active,
	input wire logic       boot_prog_allow,
	input wire logic       ext_access_allow,
	input wire logic       secure_active
);
	// ==========
	// Checks on one clock domain
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// Option bit and signature both in place
	logic sec_cause;
	assign sec_cause = mask_option_byte[EPC_BIT_SECURE_OPT] && sig_lo == EPC_SIG_VAL_LO
		&& sig_hi == EPC_SIG_VAL_HI;
	sequence ctl_rd_s; reg_rd && reg_addr == EPC_OFF_CONTROL ##1 1'b1; endsequence
	unimp_bits_a: assert property (ctl_rd_s |-> reg_rdata[7:3] == EPC_UNIMP_READ)
		else $error("upper control bits not ones");
	sense_bit_a: assert property (ctl_rd_s ##0 $stable(high_voltage_absent)
		|-> reg_rdata[EPC_BIT_HVABS] == high_voltage_absent) else $error("sense bit wrong");
	hv_cut_a: assert property (high_voltage_absent [*3]
		|-> latch_strobe_n && program_strobe_n) else $error("strobe active without voltage");
	prog_mode_a: assert property (program_active == !program_strobe_n)
		else $error("program flag and strobe disagree");
	prog_gate_a: assert property (!program_strobe_n |-> !latch_strobe_n)
		else $error("program strobe without latch strobe");
	boot_sec_a: assert property (secure_active [*2] |-> !boot_prog_allow)
		else $error("boot allowed while secure");
	boot_live_a: assert property ($past(sec_cause) |-> !boot_prog_allow)
		else $error("boot allowed with secure contents");
	ext_block_a: assert property (mask_option_byte[EPC_BIT_SECURE_OPT] [*2]
		|-> !ext_access_allow) else $error("external access not blocked");
	sec_entry_a: assert property ($rose(secure_active) |-> $past(sec_cause))
		else $error("secure without cause");
	sec_exit_a: assert property ($fell(secure_active) |-> $past(array_erased, 2))
		else $error("secure left without erase");
endmodule // epc_checker
bind epc_program_control epc_checker chk_u (.clk_sys, .rst_b, .reg_addr, .reg_rd,
	.reg_rdata, .high_voltage_absent, .mask_option_byte, .sig_lo, .sig_hi, .array_erased,
	.latch_strobe_n, .program_strobe_n, .program_active, .boot_prog_allow,
	.ext_access_allow, .secure_active);

// >>> sim/epc_array_model.sv
// Behavioural model of the EPROM array and programming supply
`timescale 1ns/1ps
module epc_array_model
	import epc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       vpp_on,
	input  wire logic       burn_opt,
	input  wire logic       burn_sig,
	input  wire logic       erase,
	input  wire logic       latch_strobe_n,
	input  wire logic       program_strobe_n,
	output logic            high_voltage_absent,
	output logic      [7:0] mask_option_byte = 8'h00,
	output logic      [7:0] sig_lo = 8'h00,
	output logic      [7:0] sig_hi = 8'h00,
	output logic            array_erased = 1'b1,
	output int              pulse_count = 0
);
	// Sense line is high while the supply is off
	assign high_voltage_absent = !vpp_on;
	// Erase clears all bytes, burns write option bit and signature
	always @(posedge clk_sys) begin
		if (erase) begin
			mask_option_byte <= 8'h00;
			sig_lo <= 8'h00;
			sig_hi <= 8'h00;
		end else begin
			if (burn_opt) mask_option_byte[EPC_BIT_SECURE_OPT] <= 1'b1;
			if (burn_sig) {sig_hi, sig_lo} <= {EPC_SIG_VAL_HI, EPC_SIG_VAL_LO};
		end
		array_erased <= erase;
		if (!program_strobe_n && !latch_strobe_n) pulse_count <= pulse_count + 1;
	end
endmodule // epc_array_model

// >>> sim/tb_epc_program_control.sv
// Self-checking bench for the EPROM program control
`timescale 1ns/1ps
module tb_epc_program_control;
	import epc_pkg::*;
	logic clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, mask_option_byte, sig_lo, sig_hi;
	logic boot_prog_req = 1'b0, ext_access_req = 1'b0, vpp_on = 1'b0, erase = 1'b1;
	logic burn_opt = 1'b0, burn_sig = 1'b0, high_voltage_absent, array_erased;
	logic latch_strobe_n, program_strobe_n, program_active;
	logic boot_prog_allow, ext_access_allow, secure_active;
	int err_total = 0, check_count = 0, cyc = 0, pulse_count, np;
	epc_program_control dut_u (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .high_voltage_absent, .mask_option_byte, .sig_lo, .sig_hi, .array_erased,
		.boot_prog_req, .ext_access_req, .latch_strobe_n, .program_strobe_n, .program_active,
		.boot_prog_allow, .ext_access_allow, .secure_active);
	epc_array_model arr_u (.clk_sys, .vpp_on, .burn_opt, .burn_sig, .erase, .latch_strobe_n,
		.program_strobe_n, .high_voltage_absent, .mask_option_byte, .sig_lo, .sig_hi,
		.array_erased, .pulse_count);
	// Clock and hang guard
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			final_report;
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic st(input logic [2:0] e);
		chk({5'h00, latch_strobe_n, program_strobe_n, program_active}, {5'h00, e});
	endtask
	task automatic fl(input logic [2:0] e);
		chk({5'h00, boot_prog_allow, ext_access_allow, secure_active}, {5'h00, e});
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic wait_set(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic final_report;
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge clk_sys);
		{rst_b, erase} <= 2'b10;
		wait_set(4);
		st(3'b110);
		fl(3'b000);
		rd(EPC_OFF_CONTROL, 8'hff);
		rd(4'h2, 8'h00);
		@(posedge clk_sys);
		vpp_on <= 1'b1;
		rd(EPC_OFF_CONTROL, 8'hfb);
		wr(EPC_OFF_CONTROL, 8'h02);
		st(3'b010);
		rd(EPC_OFF_CONTROL, 8'hfa);
		wr(EPC_OFF_CONTROL, 8'h00);
		st(3'b001);
		chk(8'(pulse_count > 0), 8'h01);
		wr(EPC_OFF_CONTROL, 8'hfa);
		st(3'b010);
		wr(EPC_OFF_CONTROL, 8'hfb);
		st(3'b110);
		rd(EPC_OFF_CONTROL, 8'hfb);
		@(posedge clk_sys);
		vpp_on <= 1'b0;
		np = pulse_count;
		wr(EPC_OFF_CONTROL, 8'h00);
		st(3'b110);
		chk(8'(pulse_count - np), 8'h00);
		rd(EPC_OFF_CONTROL, 8'hfc);
		wr(EPC_OFF_OPTION, 8'hff);
		rd(EPC_OFF_OPTION, 8'h00);
		@(posedge clk_sys);
		{boot_prog_req, ext_access_req, burn_opt} <= 3'b111;
		@(posedge clk_sys);
		burn_opt <= 1'b0;
		wait_set(6);
		fl(3'b100);
		@(posedge clk_sys);
		burn_sig <= 1'b1;
		@(posedge clk_sys);
		burn_sig <= 1'b0;
		wait_set(6);
		fl(3'b001);
		rd(EPC_OFF_SECURE, 8'h01);
		@(posedge clk_sys);
		erase <= 1'b1;
		repeat (4) @(posedge clk_sys);
		erase <= 1'b0;
		wait_set(4);
		fl(3'b110);
		final_report;
	end
endmodule // tb_epc_program_control
